// ---- rtl/flb_top.sv ----
/*
 * loopback selector of one framer channel: octet steering between the
 * line receive/transmit paths and the system highway, with an axi4-lite
 * register slave and a fifo on the line transmit path.
 * assumes octet-aligned inputs synchronous to SYS_CLK_I, one octet per
 * accepted strobe, and framing/crc engines outside that obey the flags.
 */
// Notes on behaviour
// - primary register: slot address and loop selector
// - idle code register, default 7f, fills slots
// - board loop: system back, ais to line
// - system slot loop, idle in line slot
// - line slot loop, idle in system slot
// - broadcast addressed slot also into slot zero
// - regen payload loop: line payload back, framing rebuilt
// - e1 regen loop rebuilds whole slot zero
// - receive path keeps feeding system during regen
// - connect loop: addressed system slot into zero
// - passthrough loop, only data link overwritten
// - esf passthrough excludes data link from crc
// - e1 passthrough keeps data link in crc
// - secondary loop only if distinct, unblocked
// - secondary register layout, bit 7 zero
// - secondary selector codes 00/01/10, 11 reserved
// - secondary register resets to 00
`include "flb_params.svh"
module flb_top
   import flb_pkg::*;
#(
   parameter int FIFO_DEPTH = `FLB_FIFO_DEPTH
)
(
   // clock, reset, enable
   input  wire logic        SYS_CLK_I,
   input  wire logic        NRST_I,
   input  wire logic        CE_I,
   // axi4-lite slave
   input  wire logic [7:0]  S_AXI_AWADDR_I,
   input  wire logic        S_AXI_AWVALID_I,
   output logic             S_AXI_AWREADY_O,
   input  wire logic [31:0] S_AXI_WDATA_I,
   input  wire logic [3:0]  S_AXI_WSTRB_I,
   input  wire logic        S_AXI_WVALID_I,
   output logic             S_AXI_WREADY_O,
   output logic [1:0]       S_AXI_BRESP_O,
   output logic             S_AXI_BVALID_O,
   input  wire logic        S_AXI_BREADY_I,
   input  wire logic [7:0]  S_AXI_ARADDR_I,
   input  wire logic        S_AXI_ARVALID_I,
   output logic             S_AXI_ARREADY_O,
   output logic [31:0]      S_AXI_RDATA_O,
   output logic [1:0]       S_AXI_RRESP_O,
   output logic             S_AXI_RVALID_O,
   input  wire logic        S_AXI_RREADY_I,
   // octet input stream
   input  wire logic        OCT_STB_I,
   output logic             OCT_READY_O,
   input  wire logic [4:0]  SLOT_I,
   input  wire logic [7:0]  LINE_RX_DATA_I,
   input  wire logic [7:0]  SYS_RX_DATA_I,
   // system highway transmit
   output logic [7:0]       SYS_TX_DATA_O,
   output logic             SYS_TX_VALID_O,
   // line transmit via fifo
   output logic [7:0]       LINE_TX_DATA_O,
   output logic             LINE_TX_REGEN_O,
   output logic             LINE_TX_DLINS_O,
   output logic             LINE_TX_VALID_O,
   input  wire logic        LINE_TX_READY_I,
   // framer engine control
   output logic             REGEN_FRAMING_O,
   output logic             DL_INSERT_O,
   output logic             CRC_EXCL_DL_O
);

   localparam logic [1:0] RESP_OK  = 2'b00;
   localparam logic [1:0] RESP_ERR = 2'b10;

   // the line fifo only serves power-of-two depths of at least 2
   if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0)
   begin
      $error("FIFO_DEPTH must be a power of two of at least 2");
   end

   function automatic logic f_hit(input logic [4:0] slot, input logic [4:0] addr);
      f_hit = (slot == addr);
   endfunction

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   logic [7:0]  prim_r;
   logic [7:0]  sec_r;
   logic [7:0]  idle_r;
   logic [7:0]  mode_r;
   logic        aw_got_r;
   logic        w_got_r;
   logic [7:0]  awaddr_r;
   logic [7:0]  wdata_r;
   logic        wstrb0_r;
   logic        wr_do;
   logic        wr_ok;
   logic [7:0]  stat;
   logic [7:0]  rd_val;
   logic        rd_ok;

   assign S_AXI_AWREADY_O = !aw_got_r && !S_AXI_BVALID_O;
   assign S_AXI_WREADY_O  = !w_got_r && !S_AXI_BVALID_O;
   assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;
   assign wr_do = CE_I && aw_got_r && w_got_r && !S_AXI_BVALID_O;
   assign wr_ok = (awaddr_r == `FLB_OFS_PRIM) || (awaddr_r == `FLB_OFS_SEC)
               || (awaddr_r == `FLB_OFS_IDLE) || (awaddr_r == `FLB_OFS_MODE);

   always_ff @(posedge SYS_CLK_I)
   begin
      if (!NRST_I)
      begin
         aw_got_r <= 1'b0;
         awaddr_r <= 8'h00;
      end
      else if (CE_I)
      begin
         if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)
         begin
            aw_got_r <= 1'b1;
            awaddr_r <= {S_AXI_AWADDR_I[7:2], 2'b00};
         end
         else if (wr_do)
            aw_got_r <= 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK_I)
   begin
      if (!NRST_I)
      begin
         w_got_r  <= 1'b0;
         wdata_r  <= 8'h00;
         wstrb0_r <= 1'b0;
      end
      else if (CE_I)
      begin
         if (S_AXI_WVALID_I && S_AXI_WREADY_O)
         begin
            w_got_r  <= 1'b1;
            wdata_r  <= S_AXI_WDATA_I[7:0];
            wstrb0_r <= S_AXI_WSTRB_I[0];
         end
         else if (wr_do)
            w_got_r <= 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK_I)
   begin
      if (!NRST_I)
      begin
         S_AXI_BVALID_O <= 1'b0;
         S_AXI_BRESP_O  <= RESP_OK;
      end
      else if (CE_I)
      begin
         if (wr_do)
         begin
            S_AXI_BVALID_O <= 1'b1;
            S_AXI_BRESP_O  <= wr_ok ? RESP_OK : RESP_ERR;
         end
         else if (S_AXI_BREADY_I)
            S_AXI_BVALID_O <= 1'b0;
      end
   end

   // only byte lane 0 carries register bits
   always_ff @(posedge SYS_CLK_I)
   begin
      if (!NRST_I)
      begin
         prim_r <= `FLB_PRIM_RST;
         sec_r  <= `FLB_SEC_RST;
         idle_r <= `FLB_IDLE_RST;
         mode_r <= `FLB_MODE_RST;
      end
      else if (wr_do && wstrb0_r)
      begin
         if (awaddr_r == `FLB_OFS_PRIM)
            prim_r <= wdata_r;
         if (awaddr_r == `FLB_OFS_SEC)
            sec_r <= {1'b0, wdata_r[6:0]};
         if (awaddr_r == `FLB_OFS_IDLE)
            idle_r <= wdata_r;
         if (awaddr_r == `FLB_OFS_MODE)
            mode_r <= wdata_r;
      end
   end

   always_comb
   begin
      rd_ok  = 1'b1;
      rd_val = 8'h00;
      unique case ({S_AXI_ARADDR_I[7:2], 2'b00})
         `FLB_OFS_PRIM: rd_val = prim_r;
         `FLB_OFS_SEC:  rd_val = sec_r;
         `FLB_OFS_IDLE: rd_val = idle_r;
         `FLB_OFS_MODE: rd_val = mode_r;
         `FLB_OFS_STAT: rd_val = stat;
         default:       rd_ok  = 1'b0;
      endcase
   end

   always_ff @(posedge SYS_CLK_I)
   begin
      if (!NRST_I)
      begin
         S_AXI_RVALID_O <= 1'b0;
         S_AXI_RDATA_O  <= 32'h0000_0000;
         S_AXI_RRESP_O  <= RESP_OK;
      end
      else if (CE_I)
      begin
         if (S_AXI_ARVALID_I && S_AXI_ARREADY_O)
         begin
            S_AXI_RVALID_O <= 1'b1;
            S_AXI_RDATA_O  <= {24'h00_0000, rd_val};
            S_AXI_RRESP_O  <= rd_ok ? RESP_OK : RESP_ERR;
         end
         else if (S_AXI_RREADY_I)
            S_AXI_RVALID_O <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // mode decode
   // ----------------------------------------------------------------------
   flb_prim_e  psel;
   flb_sec_e   ssel;
   logic [4:0] paddr;
   logic [4:0] saddr;
   logic       cnu;
   logic       sec_act;

   assign psel  = flb_prim_e'(prim_r[`FLB_PSEL_MSB:`FLB_PSEL_LSB]);
   assign paddr = prim_r[`FLB_ADDR_MSB:`FLB_ADDR_LSB];
   assign ssel  = flb_sec_e'(sec_r[`FLB_SSEL_MSB:`FLB_SSEL_LSB]);
   assign saddr = sec_r[`FLB_ADDR_MSB:`FLB_ADDR_LSB];
   assign cnu   = mode_r[`FLB_MODE_CNU];
   // reserved secondary code is treated as no loopback
   assign sec_act = (saddr != paddr) && (ssel == S_SYS_SLOT || ssel == S_LINE_SLOT)
                 && psel != P_LINE && psel != P_BOARD && psel != P_PAYLOAD_PASS
                 && !(psel == P_PAYLOAD_REGEN && !cnu);

   assign REGEN_FRAMING_O = (psel == P_PAYLOAD_REGEN) && !cnu;
   assign DL_INSERT_O     = (psel == P_PAYLOAD_PASS);
   // e1 gets no exclusion: far end sees crc-4 errors by design
   assign CRC_EXCL_DL_O   = DL_INSERT_O && mode_r[`FLB_MODE_ESF];
   assign stat = {5'h00, DL_INSERT_O, REGEN_FRAMING_O, sec_act};

   // ----------------------------------------------------------------------
   // octet steering
   // ----------------------------------------------------------------------
   logic        acc;
   logic        fifo_rdy;
   logic [7:0]  cap_r;
   logic [7:0]  line_nxt;
   logic [7:0]  sys_nxt;
   logic        regen_nxt;
   logic        dlins_nxt;
   logic        phit;
   logic        shit;
   logic        slot0;

   assign OCT_READY_O = fifo_rdy;
   assign acc   = CE_I && OCT_STB_I && fifo_rdy;
   assign phit  = f_hit(SLOT_I, paddr);
   assign shit  = f_hit(SLOT_I, saddr);
   assign slot0 = f_hit(SLOT_I, `FLB_SLOT_ZERO);

   // slot zero precedes the addressed slot, so it carries last frame's copy
   always_ff @(posedge SYS_CLK_I)
   begin
      if (!NRST_I)
         cap_r <= 8'h00;
      else if (acc && phit)
         cap_r <= SYS_RX_DATA_I;
   end

   always_comb
   begin
      line_nxt  = SYS_RX_DATA_I;
      sys_nxt   = LINE_RX_DATA_I;
      regen_nxt = 1'b0;
      dlins_nxt = 1'b0;
      unique case (psel)
         P_NONE: ;
         P_LINE:
            line_nxt = LINE_RX_DATA_I;
         P_BOARD:
         begin
            sys_nxt  = SYS_RX_DATA_I;
            line_nxt = `FLB_AIS_CODE;
         end
         P_SYS_SLOT:
            if (phit)
            begin
               sys_nxt  = SYS_RX_DATA_I;
               line_nxt = idle_r;
            end
         P_LINE_SLOT:
            if (phit)
            begin
               line_nxt = LINE_RX_DATA_I;
               sys_nxt  = idle_r;
            end
         P_BCAST:
            if (slot0)
               line_nxt = cap_r;
         P_PAYLOAD_REGEN:
            if (cnu)
            begin
               if (slot0)
                  sys_nxt = cap_r;
            end
            else
            begin
               line_nxt  = LINE_RX_DATA_I;
               // e1 slot zero is rebuilt whole by the transmit framer
               regen_nxt = slot0 && mode_r[`FLB_MODE_E1];
            end
         P_PAYLOAD_PASS:
         begin
            line_nxt  = LINE_RX_DATA_I;
            dlins_nxt = 1'b1;
         end
      endcase
      if (sec_act && shit)
      begin
         if (ssel == S_SYS_SLOT)
         begin
            sys_nxt  = SYS_RX_DATA_I;
            line_nxt = idle_r;
         end
         else
         begin
            line_nxt = LINE_RX_DATA_I;
            sys_nxt  = idle_r;
         end
      end
   end

   always_ff @(posedge SYS_CLK_I)
   begin
      if (!NRST_I)
      begin
         SYS_TX_DATA_O  <= 8'h00;
         SYS_TX_VALID_O <= 1'b0;
      end
      else if (CE_I)
      begin
         SYS_TX_VALID_O <= acc;
         if (acc)
            SYS_TX_DATA_O <= sys_nxt;
      end
   end

   // a stalled line side backs up into OCT_READY_O
   flb_fifo #(.WIDTH(10), .DEPTH(FIFO_DEPTH)) u_fifo
   (
      .clk_i       (SYS_CLK_I),
      .nrst_i      (NRST_I),
      .ce_i        (CE_I),
      .in_valid_i  (CE_I && OCT_STB_I),
      .in_ready_o  (fifo_rdy),
      .in_data_i   ({dlins_nxt, regen_nxt, line_nxt}),
      .out_valid_o (LINE_TX_VALID_O),
      .out_ready_i (LINE_TX_READY_I),
      .out_data_o  ({LINE_TX_DLINS_O, LINE_TX_REGEN_O, LINE_TX_DATA_O})
   );

   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   sequence s_acc_mode(flb_prim_e m);
      acc && psel == m;
   endsequence

   property p_idle_rst;
      @(posedge SYS_CLK_I) !NRST_I |=> idle_r == `FLB_IDLE_RST;
   endproperty
   a_idle_rst: assert property (p_idle_rst) else $error("idle code reset wrong");

   property p_sec_rst;
      @(posedge SYS_CLK_I) !NRST_I |=> sec_r == `FLB_SEC_RST;
   endproperty
   a_sec_rst: assert property (p_sec_rst) else $error("secondary reset wrong");

   property p_sec_rsvd;
      @(posedge SYS_CLK_I) disable iff (!NRST_I) sec_r[`FLB_SEC_RSVD] == 1'b0;
   endproperty
   a_sec_rsvd: assert property (p_sec_rsvd) else $error("reserved bit set");

   property p_board;
      @(posedge SYS_CLK_I) disable iff (!NRST_I)
         s_acc_mode(P_BOARD) |=> SYS_TX_DATA_O == $past(SYS_RX_DATA_I) && SYS_TX_VALID_O;
   endproperty
   a_board: assert property (p_board) else $error("board loop system data wrong");

   property p_sys_slot;
      @(posedge SYS_CLK_I) disable iff (!NRST_I)
         s_acc_mode(P_SYS_SLOT) ##0 phit |=> SYS_TX_DATA_O == $past(SYS_RX_DATA_I);
   endproperty
   a_sys_slot: assert property (p_sys_slot) else $error("system slot loop wrong");

   property p_line_slot;
      @(posedge SYS_CLK_I) disable iff (!NRST_I)
         s_acc_mode(P_LINE_SLOT) ##0 (phit && !sec_act) |=> SYS_TX_DATA_O == $past(idle_r);
   endproperty
   a_line_slot: assert property (p_line_slot) else $error("idle not in system slot");

   property p_cnu;
      @(posedge SYS_CLK_I) disable iff (!NRST_I)
         s_acc_mode(P_PAYLOAD_REGEN) ##0 (cnu && slot0 && !(sec_act && shit))
         |=> SYS_TX_DATA_O == $past(cap_r);
   endproperty
   a_cnu: assert property (p_cnu) else $error("connect loop slot zero wrong");

   property p_regen_rx;
      @(posedge SYS_CLK_I) disable iff (!NRST_I)
         s_acc_mode(P_PAYLOAD_REGEN) ##0 !cnu |=> SYS_TX_DATA_O == $past(LINE_RX_DATA_I);
   endproperty
   a_regen_rx: assert property (p_regen_rx) else $error("receive path stopped");

   property p_crc;
      @(posedge SYS_CLK_I) disable iff (!NRST_I)
         CRC_EXCL_DL_O == (psel == P_PAYLOAD_PASS && mode_r[`FLB_MODE_ESF]);
   endproperty
   a_crc: assert property (p_crc) else $error("crc exclusion flag wrong");

   property p_sec_gate;
      @(posedge SYS_CLK_I) disable iff (!NRST_I)
         (saddr == paddr || psel == P_LINE || psel == P_BOARD) |-> !sec_act;
   endproperty
   a_sec_gate: assert property (p_sec_gate) else $error("secondary loop not gated");

endmodule

// ---- rtl/flb_params.svh ----
/*
 * constants of the loopback selector: register offsets, field positions,
 * reset values and fixed codes.
 * assumes inclusion by bare name from every design file that needs them.
 */
`ifndef FLB_PARAMS_SVH
`define FLB_PARAMS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define FLB_OFS_PRIM      8'h00
`define FLB_OFS_SEC       8'h04
`define FLB_OFS_IDLE      8'h08
`define FLB_OFS_MODE      8'h0c
`define FLB_OFS_STAT      8'h10

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define FLB_ADDR_LSB      0
`define FLB_ADDR_MSB      4
`define FLB_PSEL_LSB      5
`define FLB_PSEL_MSB      7
`define FLB_SSEL_LSB      5
`define FLB_SSEL_MSB      6
`define FLB_SEC_RSVD      7
`define FLB_MODE_E1       0
`define FLB_MODE_ESF      1
`define FLB_MODE_CNU      3

// ----------------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------------
`define FLB_PRIM_RST      8'h00
`define FLB_SEC_RST       8'h00
`define FLB_IDLE_RST      8'h7f
`define FLB_MODE_RST      8'h00
`define FLB_AIS_CODE      8'hff
`define FLB_SLOT_ZERO     5'h00
`define FLB_FIFO_DEPTH    8

`endif

// ---- rtl/flb_pkg.sv ----
/*
 * types of the loopback selector: primary and secondary mode codes.
 * assumes flb_params.svh for the numeric constants.
 */
package flb_pkg;

   // order of the literals is the selector code 0..7
   typedef enum logic [2:0]
   {
      P_NONE, P_LINE, P_BOARD, P_SYS_SLOT, P_LINE_SLOT, P_BCAST, P_PAYLOAD_REGEN,
      P_PAYLOAD_PASS
   } flb_prim_e;

   typedef enum logic [1:0]
   {
      S_NONE, S_SYS_SLOT, S_LINE_SLOT, S_RSVD
   } flb_sec_e;

   typedef logic [7:0] flb_octet_t;

endpackage

// ---- rtl/flb_fifo.sv ----
/*
 * flop-based fifo with valid/ready on both sides.
 * assumes one clock, synchronous active-low reset and a clock enable.
 */
`include "flb_params.svh"
module flb_fifo
   import flb_pkg::*;
#(
   parameter int WIDTH = 10,
   parameter int DEPTH = `FLB_FIFO_DEPTH
)
(
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             nrst_i,
   input  wire logic             ce_i,
   // fill side
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   // drain side
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   // full/empty come from the pointer wrap bit, which needs a power of two
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
   begin
      $error("fifo depth must be a power of two of at least 2");
   end

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0]      wp_r;
   logic [AW:0]      rp_r;
   logic             full;
   logic             empty;
   logic             push;
   logic             pop;

   assign full        = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
   assign empty       = (wp_r == rp_r);
   assign in_ready_o  = !full;
   assign out_valid_o = !empty;
   assign out_data_o  = mem_r[rp_r[AW-1:0]];
   assign push        = ce_i && in_valid_i && !full;
   assign pop         = ce_i && out_ready_i && !empty;

   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
         wp_r <= '0;
      else if (push)
         wp_r <= wp_r + 1'b1;
   end

   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
         rp_r <= '0;
      else if (pop)
         rp_r <= rp_r + 1'b1;
   end

   // storage needs no reset: nothing reads a slot before it is written
   always_ff @(posedge clk_i)
   begin
      if (push)
         mem_r[wp_r[AW-1:0]] <= in_data_i;
   end

endmodule

// ---- verification/flb_line_sink.sv ----
/*
 * line transmit sink: pops the fifo head, keeps the last octet and a count.
 * assumes the bench drives stall_i off the sampling edge.
 */
module flb_line_sink
(
   // clock
   input  wire logic       clk_i,
   // fifo head
   input  wire logic       valid_i,
   input  wire logic [9:0] data_i,
   output logic            ready_o,
   // control and record
   input  wire logic       stall_i,
   output logic [9:0]      last_o,
   output logic [7:0]      cnt_o
);
   // -----------------------------
   // pop side
   // -----------------------------
   assign ready_o = !stall_i;
   initial cnt_o = 8'h00;
   always @(posedge clk_i)
   begin
      if (valid_i && ready_o)
      begin
         last_o <= data_i;
         cnt_o  <= cnt_o + 8'h01;
      end
   end
endmodule

// ---- verification/framer_loopback_control_tb_top.sv ----
/*
 * bench of the loopback selector: register access, octet steering per
 * loop mode, fifo back-pressure.
 * assumes flb_top, its fifo and flb_line_sink are compiled before it.
 */
`include "flb_params.svh"
module framer_loopback_control_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        awv = 1'b0;
   logic        wv = 1'b0;
   logic        bready = 1'b0;
   logic        arv = 1'b0;
   logic        rready = 1'b0;
   logic        stb = 1'b0;
   logic        stall = 1'b0;
   logic [4:0]  slot = 5'h00;
   logic [7:0]  lrx = 8'h00;
   logic [7:0]  srx = 8'h00;
   logic        awr, wr_rdy, bv, arr, rv, ordy, stv, ltv, lrdy, rg, dli, ltrg, ltdl, crx;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [7:0]  stx, ltx, cnt;
   logic [9:0]  last;
   int          fail_count = 0;
   int          n_compared = 0;

   always #50 clk = ~clk;

   flb_top DUT
   (
      .SYS_CLK_I(clk), .NRST_I(nrst), .CE_I(1'b1),
      .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
      .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'h1), .S_AXI_WVALID_I(wv),
      .S_AXI_WREADY_O(wr_rdy), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv),
      .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arv),
      .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
      .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rready),
      .OCT_STB_I(stb), .OCT_READY_O(ordy), .SLOT_I(slot),
      .LINE_RX_DATA_I(lrx), .SYS_RX_DATA_I(srx),
      .SYS_TX_DATA_O(stx), .SYS_TX_VALID_O(stv),
      .LINE_TX_DATA_O(ltx), .LINE_TX_REGEN_O(ltrg), .LINE_TX_DLINS_O(ltdl),
      .LINE_TX_VALID_O(ltv), .LINE_TX_READY_I(lrdy),
      .REGEN_FRAMING_O(rg), .DL_INSERT_O(dli), .CRC_EXCL_DL_O(crx)
   );

   flb_line_sink SINK
   (
      .clk_i(clk), .valid_i(ltv), .data_i({ltdl, ltrg, ltx}), .ready_o(lrdy),
      .stall_i(stall), .last_o(last), .cnt_o(cnt)
   );

   // -----------------------------
   // shared tasks
   // -----------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         $display("ERROR %0t got %h exp %h", $time, got, exp);
         fail_count++;
      end
   endtask

   task automatic tally_and_finish();
      if (fail_count == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // address and data offered together, each released once taken
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      logic ta, tw;
      @(posedge clk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(negedge clk);
         ta = awv && awr;
         tw = wv && wr_rdy;
         @(posedge clk);
         if (ta) awv <= 1'b0;
         if (tw) wv <= 1'b0;
      end while (awv || wv);
      do @(negedge clk); while (!bv);
      chk(bresp, er);
      @(posedge clk);
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
      @(posedge clk);
      araddr <= a;
      arv <= 1'b1;
      rready <= 1'b1;
      do @(negedge clk); while (!arr);
      @(posedge clk);
      arv <= 1'b0;
      do @(negedge clk); while (!rv);
      chk(rdata, {24'h0, ed});
      chk(rresp, er);
      @(posedge clk);
      rready <= 1'b0;
   endtask

   // one octet in; system output next cycle, line output once popped
   task automatic oct(input logic [4:0] s, input logic [7:0] l, input logic [7:0] y,
                      input logic [7:0] el, input logic [7:0] es);
      @(posedge clk);
      slot <= s;
      lrx <= l;
      srx <= y;
      stb <= 1'b1;
      do @(negedge clk); while (!ordy);
      @(posedge clk);
      stb <= 1'b0;
      lrx <= ~l;
      srx <= ~y;
      @(negedge clk);
      chk(stv, 1'b1);
      chk(stx, es);
      repeat (2) @(negedge clk);
      chk(last[7:0], el);
   endtask

   // -----------------------------
   // scenarios
   // -----------------------------
   task automatic t_regs();
      rd(`FLB_OFS_SEC, 8'h00, 2'b00);
      rd(`FLB_OFS_IDLE, 8'h7f, 2'b00);
      rd(`FLB_OFS_PRIM, 8'h00, 2'b00);
      rd(8'h20, 8'h00, 2'b10);
      wr(8'h20, 8'h55, 2'b10);
      wr(`FLB_OFS_SEC, 8'hff, 2'b00);
      rd(`FLB_OFS_SEC, 8'h7f, 2'b00);
      wr(`FLB_OFS_SEC, 8'h00, 2'b00);
   endtask

   task automatic t_full_loops();
      wr(`FLB_OFS_PRIM, 8'h20, 2'b00);
      oct(5'd3, 8'h11, 8'h22, 8'h11, 8'h11);
      wr(`FLB_OFS_PRIM, 8'h40, 2'b00);
      oct(5'd3, 8'h11, 8'h22, `FLB_AIS_CODE, 8'h22);
   endtask

   task automatic t_slot_loops();
      wr(`FLB_OFS_PRIM, 8'h65, 2'b00);
      oct(5'd5, 8'h11, 8'h22, 8'h7f, 8'h22);
      oct(5'd6, 8'h33, 8'h44, 8'h44, 8'h33);
      oct(5'd5, 8'h55, 8'h66, 8'h7f, 8'h66);
      wr(`FLB_OFS_IDLE, 8'h3c, 2'b00);
      wr(`FLB_OFS_PRIM, 8'h85, 2'b00);
      oct(5'd5, 8'h11, 8'h22, 8'h11, 8'h3c);
      oct(5'd4, 8'h11, 8'h22, 8'h22, 8'h11);
   endtask

   task automatic t_secondary();
      wr(`FLB_OFS_SEC, 8'h25, 2'b00);
      oct(5'd5, 8'h11, 8'h22, 8'h11, 8'h3c);
      wr(`FLB_OFS_PRIM, 8'h00, 2'b00);
      wr(`FLB_OFS_SEC, 8'h47, 2'b00);
      oct(5'd7, 8'h11, 8'h22, 8'h11, 8'h3c);
      wr(`FLB_OFS_SEC, 8'h27, 2'b00);
      oct(5'd7, 8'h11, 8'h22, 8'h3c, 8'h22);
      wr(`FLB_OFS_PRIM, 8'h40, 2'b00);
      oct(5'd7, 8'h11, 8'h22, `FLB_AIS_CODE, 8'h22);
      wr(`FLB_OFS_PRIM, 8'h00, 2'b00);
      wr(`FLB_OFS_SEC, 8'h67, 2'b00);
      oct(5'd7, 8'h11, 8'h22, 8'h22, 8'h11);
      wr(`FLB_OFS_SEC, 8'h00, 2'b00);
   endtask

   task automatic t_slot_zero();
      wr(`FLB_OFS_PRIM, 8'ha5, 2'b00);
      oct(5'd5, 8'h11, 8'h77, 8'h77, 8'h11);
      oct(5'd0, 8'h12, 8'h34, 8'h77, 8'h12);
      wr(`FLB_OFS_MODE, 8'h08, 2'b00);
      wr(`FLB_OFS_PRIM, 8'hc5, 2'b00);
      chk({rg, dli, crx}, 3'b000);
      oct(5'd5, 8'h11, 8'h99, 8'h99, 8'h11);
      oct(5'd0, 8'h12, 8'h34, 8'h34, 8'h99);
   endtask

   task automatic t_payload();
      wr(`FLB_OFS_MODE, 8'h01, 2'b00);
      wr(`FLB_OFS_PRIM, 8'hc0, 2'b00);
      chk({rg, dli, crx}, 3'b100);
      oct(5'd2, 8'h11, 8'h22, 8'h11, 8'h11);
      chk(last[9:8], 2'b00);
      oct(5'd0, 8'h11, 8'h22, 8'h11, 8'h11);
      chk(last[9:8], 2'b01);
      wr(`FLB_OFS_MODE, 8'h02, 2'b00);
      wr(`FLB_OFS_PRIM, 8'he0, 2'b00);
      chk({rg, dli, crx}, 3'b011);
      oct(5'd2, 8'h11, 8'h22, 8'h11, 8'h11);
      chk(last[9:8], 2'b10);
      wr(`FLB_OFS_MODE, 8'h01, 2'b00);
      chk({rg, dli, crx}, 3'b010);
   endtask

   // sink stalls while eight octets fill the fifo; a ninth is refused
   task automatic t_fill();
      logic [7:0] c0;
      wr(`FLB_OFS_PRIM, 8'h00, 2'b00);
      c0 = cnt;
      @(posedge clk);
      stall <= 1'b1;
      srx <= 8'h80;
      stb <= 1'b1;
      for (int i = 1; i <= 8; i++)
      begin
         @(posedge clk);
         srx <= 8'h80 + 8'(i);
      end
      @(posedge clk);
      stb <= 1'b0;
      @(negedge clk);
      chk(ordy, 1'b0);
      chk(stv, 1'b0);
      @(posedge clk);
      stall <= 1'b0;
      repeat (12) @(negedge clk);
      chk(ltv, 1'b0);
      chk(cnt - c0, 8'h08);
      chk(last, 8'h87);
   endtask

   // -----------------------------
   // sequence and watchdog
   // -----------------------------
   initial
   begin
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      t_regs();
      t_full_loops();
      t_slot_loops();
      t_secondary();
      t_slot_zero();
      t_payload();
      t_fill();
      tally_and_finish();
   end

   initial
   begin
      #2000000;
      fail_count++;
      tally_and_finish();
   end
endmodule
